// ---- inc/i2cms_pkg.sv ----
// Constants, state codes and register map of the transfer sequencer
// Assumes a 20 MHz APB clock and an open-drain two-wire bus
package i2cms_pkg;
    // Bus timing, one quarter of an SCL period
    localparam int unsigned CLK_NS   = 50;
    localparam int unsigned QTR_NS   = 2500;
    localparam int unsigned QTR_CYC  = QTR_NS / CLK_NS;
    localparam logic [5:0]  QTR_LAST = 6'(QTR_CYC - 1);
    // Register indices, byte address is four times the index
    localparam logic [11:0] IDX_DATA = 12'hf50;
    localparam logic [11:0] IDX_STAT = 12'hf51;
    localparam logic [11:0] IDX_CTRL = 12'hf52;
    // Status bit positions
    localparam int unsigned SB_TXE   = 7;
    localparam int unsigned SB_RXF   = 6;
    localparam int unsigned SB_ACK   = 5;
    localparam int unsigned SB_RD    = 3;
    localparam int unsigned SB_BUSY  = 1;
    localparam int unsigned SB_NACKI = 0;
    // Control bit positions
    localparam int unsigned CB_EN    = 7;
    localparam int unsigned CB_START = 6;
    localparam int unsigned CB_STOP  = 5;
    localparam int unsigned CB_TXIRQ = 4;
    localparam int unsigned CB_NAK   = 3;
    localparam int unsigned CB_FLUSH = 2;
    // Values after reset
    localparam logic [7:0]  DATA_RST = 8'h00;
    localparam logic        TXE_RST  = 1'h1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_BIT   = 3'b010,
        ST_ACK   = 3'b011,
        ST_HOLD  = 3'b100,
        ST_STOP  = 3'b101
    } i2cms_state_t;

    function automatic logic i2cms_hit(input logic [13:0] a, input logic [11:0] idx);
        return a == {idx, 2'h0};
    endfunction : i2cms_hit
endpackage : i2cms_pkg

// ---- src/i2cms_seq.sv ----
// Two-wire master transfer sequencer with APB register access
// Assumes open-drain SCL/SDA resolved outside, pins asynchronous to pclk
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module i2cms_seq
    import i2cms_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Two-wire pins
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Interrupt request
    output logic             irq
);
    i2cms_state_t st_ff, nxt_st;
    logic [1:0]  ph_ff, nxt_ph;
    logic [5:0]  qcnt_ff, nxt_qcnt;
    logic [2:0]  bcnt_ff, nxt_bcnt;
    logic [7:0]  sh_ff, nxt_sh;
    logic [7:0]  data_ff, nxt_data;
    logic        first_ff, nxt_first;
    logic        rd_ff, nxt_rd;
    logic        en_ff, nxt_en;
    logic        start_ff, nxt_start;
    logic        stop_ff, nxt_stop;
    logic        txie_ff, nxt_txie;
    logic        nak_ff, nxt_nak;
    logic        txe_ff, nxt_txe;
    logic        rxf_ff, nxt_rxf;
    logic        ack_ff, nxt_ack;
    logic        nacki_ff, nxt_nacki;
    logic        scl_oe_ff, nxt_scl_oe;
    logic        sda_oe_ff, nxt_sda_oe;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        sda_m_ff, sda_s_ff;
    logic        scl_m_ff, scl_s_ff;
    logic        sda_v;
    logic [7:0]  stat_val, ctrl_val;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_m_ff <= 1'h1;
            sda_s_ff <= 1'h1;
            scl_m_ff <= 1'h1;
            scl_s_ff <= 1'h1;
        end else begin
            sda_m_ff <= sda_i;
            sda_s_ff <= sda_m_ff;
            scl_m_ff <= scl_i;
            scl_s_ff <= scl_m_ff;
        end
    end

    // APB decode
    wire       acc     = psel & penable;
    wire       hit_dat = i2cms_hit(paddr, IDX_DATA);
    wire       hit_sta = i2cms_hit(paddr, IDX_STAT);
    wire       hit_ctl = i2cms_hit(paddr, IDX_CTRL);
    wire       wr_dat  = acc & pwrite & hit_dat;
    wire       rd_dat  = acc & ~pwrite & hit_dat;
    wire       wr_ctl  = acc & pwrite & hit_ctl;
    wire [7:0] wb      = pwdata[7:0];
    wire       flush   = wr_ctl & wb[CB_FLUSH];

    // Bit timing
    wire phased   = (st_ff != ST_IDLE) && (st_ff != ST_HOLD);
    wire stall    = ~scl_oe_ff & ~scl_s_ff;
    wire tick     = phased & ~stall & (qcnt_ff == QTR_LAST);
    wire done     = tick & (ph_ff == 2'h3);
    wire smp      = tick & (ph_ff == 2'h2);
    wire rx_mode  = rd_ff & ~first_ff;
    wire first_tx = (st_ff == ST_BIT) & done & (bcnt_ff == 3'h0) & ~rx_mode;
    wire ack_smp  = (st_ff == ST_ACK) & smp & ~rx_mode;
    wire tx_end   = (st_ff == ST_ACK) & done & ~rx_mode;
    wire rx_end   = (st_ff == ST_ACK) & done & rx_mode;
    wire clr_strt = (st_ff == ST_START) & done;
    wire clr_stop = (st_ff == ST_STOP) & done;

    // Pull-down wanted on SDA per state, one drives the wire low
    always_comb begin
        case (st_ff)
            ST_START: sda_v = (ph_ff == 2'h3);
            ST_STOP:  sda_v = (ph_ff != 2'h3);
            ST_BIT:   sda_v = ~rx_mode & ~sh_ff[7];
            ST_ACK:   sda_v = rx_mode & ~nak_ff;
            default:  sda_v = 1'h0;
        endcase
    end

    assign nxt_scl_oe = (st_ff == ST_HOLD) | (phased & ~ph_ff[1]);
    assign nxt_sda_oe = (st_ff == ST_IDLE) ? 1'h0 :
                        ((st_ff == ST_HOLD) | (ph_ff == 2'h0)) ? sda_oe_ff : sda_v;
    assign nxt_qcnt   = (~phased | tick) ? 6'h00 :
                        stall ? qcnt_ff : 6'(qcnt_ff + 6'h01);

    // Transfer sequencing
    always_comb begin
        nxt_st    = st_ff;
        nxt_ph    = tick ? 2'(ph_ff + 2'h1) : ph_ff;
        nxt_sh    = sh_ff;
        nxt_bcnt  = bcnt_ff;
        nxt_first = first_ff;
        nxt_rd    = rd_ff;
        case (st_ff)
            ST_IDLE: begin
                if (en_ff & start_ff) begin
                    nxt_st = ST_START;
                end
            end
            ST_START: begin
                if (done) begin
                    nxt_st    = ST_BIT;
                    nxt_sh    = data_ff;
                    nxt_rd    = data_ff[0];
                    nxt_first = 1'h1;
                    nxt_bcnt  = 3'h0;
                end
            end
            ST_BIT: begin
                if (smp & rx_mode) begin
                    nxt_sh = {sh_ff[6:0], sda_s_ff};
                end
                if (done) begin
                    if (~rx_mode) begin
                        nxt_sh = {sh_ff[6:0], 1'h0};
                    end
                    nxt_bcnt = 3'(bcnt_ff + 3'h1);
                    if (bcnt_ff == 3'h7) begin
                        nxt_st = ST_ACK;
                    end
                end
            end
            ST_ACK: begin
                if (done) begin
                    nxt_st    = ST_HOLD;
                    nxt_first = 1'h0;
                end
            end
            ST_HOLD: begin
                if (stop_ff) begin
                    nxt_st = ST_STOP;
                end else if (start_ff) begin
                    nxt_st = ST_START;
                end else if (~nacki_ff & (rx_mode ? ~rxf_ff : ~txe_ff)) begin
                    nxt_st = ST_BIT;
                    if (~rx_mode) begin
                        nxt_sh = data_ff;
                    end
                end
            end
            ST_STOP: begin
                if (done) begin
                    nxt_st = ST_IDLE;
                    nxt_rd = 1'h0;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
        if (~en_ff) begin
            nxt_st = ST_IDLE;
            nxt_ph = 2'h0;
        end
    end

    // Control register, a written one wins over the hardware clear
    assign nxt_en    = wr_ctl ? wb[CB_EN] : en_ff;
    assign nxt_txie  = wr_ctl ? wb[CB_TXIRQ] : txie_ff;
    assign nxt_start = wr_ctl ? wb[CB_START] : (clr_strt ? 1'h0 : start_ff);
    assign nxt_stop  = wr_ctl ? wb[CB_STOP] : (clr_stop ? 1'h0 : stop_ff);
    assign nxt_nak   = wr_ctl ? wb[CB_NAK] : (clr_stop ? 1'h0 : nak_ff);

    assign nxt_txe   = wr_dat ? 1'h0 : ((first_tx | flush) ? 1'h1 : txe_ff);
    assign nxt_rxf   = rx_end ? 1'h1 : (rd_dat ? 1'h0 : rxf_ff);
    assign nxt_data  = rx_end ? sh_ff : (wr_dat ? wb : data_ff);
    assign nxt_ack   = ack_smp ? ~sda_s_ff : ack_ff;
    wire   tx_refuse = tx_end & ~ack_ff & ~stop_ff & ~start_ff;
    wire   rx_refuse = rx_end & nak_ff;
    assign nxt_nacki = (tx_refuse | rx_refuse) ? 1'h1 : (clr_stop ? 1'h0 : nacki_ff);

    // Read data
    always_comb begin
        stat_val           = 8'h00;
        stat_val[SB_TXE]   = txe_ff;
        stat_val[SB_RXF]   = rxf_ff;
        stat_val[SB_ACK]   = ack_ff;
        stat_val[SB_RD]    = rd_ff;
        stat_val[SB_BUSY]  = (st_ff != ST_IDLE);
        stat_val[SB_NACKI] = nacki_ff;
        ctrl_val           = 8'h00;
        ctrl_val[CB_EN]    = en_ff;
        ctrl_val[CB_START] = start_ff;
        ctrl_val[CB_STOP]  = stop_ff;
        ctrl_val[CB_TXIRQ] = txie_ff;
        ctrl_val[CB_NAK]   = nak_ff;
    end
    assign nxt_prdata = ~(psel & ~penable) ? prdata_ff :
                        hit_dat ? {24'h000000, data_ff} :
                        hit_sta ? {24'h000000, stat_val} :
                        hit_ctl ? {24'h000000, ctrl_val} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff     <= ST_IDLE;
            ph_ff     <= 2'h0;
            qcnt_ff   <= 6'h00;
            bcnt_ff   <= 3'h0;
            sh_ff     <= 8'h00;
            data_ff   <= DATA_RST;
            first_ff  <= 1'h0;
            rd_ff     <= 1'h0;
            en_ff     <= 1'h0;
            start_ff  <= 1'h0;
            stop_ff   <= 1'h0;
            txie_ff   <= 1'h0;
            nak_ff    <= 1'h0;
            txe_ff    <= TXE_RST;
            rxf_ff    <= 1'h0;
            ack_ff    <= 1'h0;
            nacki_ff  <= 1'h0;
            scl_oe_ff <= 1'h0;
            sda_oe_ff <= 1'h0;
            prdata_ff <= 32'h00000000;
        end else begin
            st_ff     <= nxt_st;
            ph_ff     <= nxt_ph;
            qcnt_ff   <= nxt_qcnt;
            bcnt_ff   <= nxt_bcnt;
            sh_ff     <= nxt_sh;
            data_ff   <= nxt_data;
            first_ff  <= nxt_first;
            rd_ff     <= nxt_rd;
            en_ff     <= nxt_en;
            start_ff  <= nxt_start;
            stop_ff   <= nxt_stop;
            txie_ff   <= nxt_txie;
            nak_ff    <= nxt_nak;
            txe_ff    <= nxt_txe;
            rxf_ff    <= nxt_rxf;
            ack_ff    <= nxt_ack;
            nacki_ff  <= nxt_nacki;
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
            prdata_ff <= nxt_prdata;
        end
    end

    // Outputs
    assign prdata  = prdata_ff;
    assign pready  = 1'h1;
    assign pslverr = acc & ~(hit_dat | hit_sta | hit_ctl);
    assign scl_o   = 1'h0;
    assign sda_o   = 1'h0;
    assign scl_oe  = scl_oe_ff;
    assign sda_oe  = sda_oe_ff;
    assign irq     = en_ff & ((txie_ff & txe_ff) | rxf_ff | nacki_ff);

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_stop_end;
        (st_ff == ST_STOP) && done && !wr_ctl;
    endsequence
    sequence s_idle_clean;
        (st_ff == ST_IDLE) && !stop_ff && !nacki_ff;
    endsequence

    a_empty_first_bit: assert property (first_tx && !wr_dat |=> txe_ff)
        else $error("data register not freed after first bit");
    a_irq_tx_empty: assert property (first_tx && !wr_dat && !wr_ctl && en_ff
                                     && txie_ff |=> irq)
        else $error("no transmit interrupt after first bit");
    a_irq_enabled: assert property (en_ff && txie_ff && $rose(txe_ff) |-> irq)
        else $error("empty data register did not interrupt");
    a_start_load: assert property (clr_strt |=> st_ff == ST_BIT && sh_ff == $past(data_ff))
        else $error("shifter not loaded after start");
    a_ack_sample: assert property (ack_smp |=> ack_ff == !$past(sda_s_ff))
        else $error("acknowledge bit not sampled");
    a_nack_clears_ack: assert property ($rose(nacki_ff) && !$past(rx_mode) |-> !ack_ff)
        else $error("refusal left acknowledge set");
    a_nack_masked: assert property ($rose(nacki_ff) && !$past(rx_mode)
                                    |-> $past(!stop_ff && !start_ff))
        else $error("refusal raised with stop or start pending");
    a_stop_clears: assert property (s_stop_end |=> s_idle_clean)
        else $error("stop did not clear stop and refused flags");
    a_restart_clear: assert property ($fell(start_ff) && !$past(wr_ctl)
                                      |-> $past(st_ff) == ST_START)
        else $error("start bit cleared outside start condition");
    a_rx_answer: assert property ((st_ff == ST_ACK) && rx_mode && ph_ff == 2'h2
                                  |-> sda_oe_ff == !nak_ff)
        else $error("wrong answer to received byte");
    a_rx_full: assert property (rx_end |=> rxf_ff && data_ff == $past(sh_ff)
                                && irq == en_ff)
        else $error("received byte not flagged");
    a_rd_clear: assert property (rd_dat && !rx_end |=> !rxf_ff)
        else $error("data read did not clear receive full");
    a_rx_refused: assert property (rx_end && nak_ff |=> nacki_ff)
        else $error("refused read byte not flagged");
    a_sda_low_scl: assert property ($changed(sda_oe_ff) && $past(st_ff) == ST_BIT
                                    |-> scl_oe_ff && $past(scl_oe_ff))
        else $error("SDA moved while SCL released");
    a_flush_empty: assert property (flush |=> txe_ff)
        else $error("flush left data register full");
endmodule : i2cms_seq

// ---- verif/i2cms_slv.sv ----
// Behavioural two-wire slave facing the transfer sequencer
// Assumes open-drain wires with pull-ups resolved by the bench
`timescale 1ns/1ns
module i2cms_slv (
    // Wire levels
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_oe,
    // Behaviour controls
    input  wire logic       refuse,
    input  wire logic [7:0] rd_base
);
    logic [7:0] rx_q[$];
    logic       mack_q[$];
    int         stops = 0;
    logic       last_stop = 1'b1;
    event       st_ev;
    event       sp_ev;

    // Start and stop seen on the wires
    always @(posedge sda or negedge sda) if (scl === 1'b1) begin
        if (sda === 1'b1) begin
            last_stop = 1'b1;
            stops++;
            -> sp_ev;
        end else if (sda === 1'b0) begin
            last_stop = 1'b0;
            -> st_ev;
        end
    end

    task automatic get_byte(output logic [7:0] b);
        @(negedge scl);
        sda_oe = 1'b0;
        repeat (8) begin
            @(posedge scl);
            b = {b[6:0], sda};
        end
    endtask : get_byte

    task automatic txn();
        logic [7:0] b;
        logic       nak;
        get_byte(b);
        rx_q.push_back(b);
        @(negedge scl);
        sda_oe = !refuse;
        if (b[0] && !refuse) begin
            b   = rd_base;
            nak = 1'b0;
            while (!nak) begin
                for (int i = 7; i >= 0; i--) begin
                    @(negedge scl);
                    sda_oe = !b[i];
                end
                @(negedge scl);
                sda_oe = 1'b0;
                @(posedge scl);
                nak = sda;
                mack_q.push_back(!nak);
                b++;
            end
        end else begin
            forever begin
                get_byte(b);
                rx_q.push_back(b);
                @(negedge scl);
                sda_oe = !refuse;
            end
        end
    endtask : txn

    // One transaction per start, cut short by stop or repeated start
    initial begin
        sda_oe = 1'b0;
        @(st_ev);
        forever begin
            fork
                txn();
            join_none
            @(st_ev or sp_ev);
            disable fork;
            sda_oe = 1'b0;
            if (last_stop) begin
                @(st_ev);
            end
        end
    end
endmodule : i2cms_slv

// ---- verif/testbench.sv ----
// Self-checking bench: APB register traffic and two-wire transfers
// Assumes the slave model on pulled-up wires, 20 MHz clock
`timescale 1ns/1ns
module testbench;
    import i2cms_pkg::*;
    localparam logic [7:0] EN = 8'h01 << CB_EN;
    localparam logic [7:0] GO = 8'h01 << CB_START;
    localparam logic [7:0] SP = 8'h01 << CB_STOP;
    localparam logic [7:0] TX = 8'h01 << CB_TXIRQ;
    localparam logic [7:0] NK = 8'h01 << CB_NAK;
    localparam logic [7:0] FL = 8'h01 << CB_FLUSH;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        scl_oe, sda_oe, slv_oe, refuse, err;
    logic [7:0]  rd_base, d;
    int          mismatches, num_checks, stops0;
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || slv_oe);

    i2cms_seq i2cms_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq));
    i2cms_slv i2cms_slv_inst (.scl(scl), .sda(sda), .sda_oe(slv_oe), .refuse(refuse),
        .rd_base(rd_base));

    always #25 pclk = ~pclk;

    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        d = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("pready", 8'h01, 8'h00);
            give_verdict();
        end
        @(posedge pclk);
    endtask : apb

    function automatic logic [7:0] bt(input int p);
        return {7'h00, d[p]};
    endfunction : bt

    task automatic wt(input int p, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, IDX_STAT, 8'h00);
            n++;
        end while (d[p] !== v && n < 3000);
        if (n >= 3000) begin
            chk("status_wait", {7'h00, v}, bt(p));
            give_verdict();
        end
    endtask : wt

    task automatic chk_stop();
        chk("stop_count", 8'(stops0 + 1), 8'(i2cms_slv_inst.stops));
    endtask : chk_stop

    task automatic t_reset();
        apb(1'b0, IDX_STAT, 8'h00);
        chk("status_reset", 8'h80, d);
        chk("irq_reset", 8'h00, {7'h00, irq});
        apb(1'b1, IDX_STAT, 8'h00);
        apb(1'b0, IDX_STAT, 8'h00);
        chk("status_ro", 8'h80, d);
        apb(1'b0, 12'h000, 8'h00);
        chk("unmapped_err", 8'h01, {7'h00, err});
        apb(1'b1, IDX_CTRL, EN);
        chk("irq_en_only", 8'h00, {7'h00, irq});
        apb(1'b1, IDX_CTRL, EN | TX);
        chk("irq_tx_empty", 8'h01, {7'h00, irq});
    endtask : t_reset

    task automatic t_write10();
        logic [7:0] e [3];
        e = '{8'hf2, 8'h34, 8'h5a};
        i2cms_slv_inst.rx_q.delete();
        stops0 = i2cms_slv_inst.stops;
        apb(1'b1, IDX_DATA, e[0]);
        apb(1'b1, IDX_CTRL, EN | GO | TX);
        wt(SB_TXE, 1'b1);
        chk("busy_first_bit", 8'h01, bt(SB_BUSY));
        chk("irq_first_bit", 8'h01, {7'h00, irq});
        apb(1'b1, IDX_DATA, e[1]);
        wt(SB_TXE, 1'b1);
        chk("ack_addr", 8'h01, bt(SB_ACK));
        apb(1'b1, IDX_DATA, e[2]);
        wt(SB_TXE, 1'b1);
        chk("irq_each_byte", 8'h01, {7'h00, irq});
        // stop in last byte, no tx irq
        apb(1'b1, IDX_CTRL, EN | SP);
        refuse <= 1'b1;
        wt(SB_BUSY, 1'b0);
        chk("refused_last", 8'h00, bt(SB_NACKI));
        chk("irq_after_stop", 8'h00, {7'h00, irq});
        apb(1'b0, IDX_CTRL, 8'h00);
        chk("stop_cleared", 8'h00, d & SP);
        chk_stop();
        for (int i = 0; i < 3; i++) begin
            chk("wire_byte", e[i], i2cms_slv_inst.rx_q[i]);
        end
        refuse <= 1'b0;
    endtask : t_write10

    task automatic t_restart();
        i2cms_slv_inst.rx_q.delete();
        stops0 = i2cms_slv_inst.stops;
        apb(1'b1, IDX_DATA, 8'ha0);
        apb(1'b1, IDX_CTRL, EN | GO | TX);
        wt(SB_TXE, 1'b1);
        apb(1'b1, IDX_DATA, 8'h55);
        wt(SB_TXE, 1'b1);
        apb(1'b1, IDX_CTRL, EN | GO);
        apb(1'b1, IDX_DATA, 8'ha0);
        wt(SB_TXE, 1'b1);
        apb(1'b0, IDX_CTRL, 8'h00);
        chk("start_cleared", 8'h00, d & GO);
        apb(1'b1, IDX_CTRL, EN | SP);
        wt(SB_BUSY, 1'b0);
        chk_stop();
        chk("restart_bytes", 8'h03, 8'(i2cms_slv_inst.rx_q.size()));
        chk("restart_addr", 8'ha0, i2cms_slv_inst.rx_q[2]);
    endtask : t_restart

    task automatic t_read();
        stops0 = i2cms_slv_inst.stops;
        rd_base <= 8'h3c;
        apb(1'b1, IDX_DATA, 8'ha1);
        apb(1'b1, IDX_CTRL, EN | GO);
        wt(SB_RXF, 1'b1);
        chk("irq_rx_full", 8'h01, {7'h00, irq});
        chk("ack_read_addr", 8'h01, bt(SB_ACK));
        apb(1'b1, IDX_CTRL, EN | NK);
        apb(1'b0, IDX_DATA, 8'h00);
        chk("rx_first", 8'h3c, d);
        apb(1'b0, IDX_STAT, 8'h00);
        chk("rx_full_clear", 8'h00, bt(SB_RXF));
        wt(SB_RXF, 1'b1);
        chk("refused_read", 8'h01, bt(SB_NACKI));
        apb(1'b0, IDX_DATA, 8'h00);
        chk("rx_second", 8'h3d, d);
        apb(1'b1, IDX_CTRL, EN | SP);
        wt(SB_BUSY, 1'b0);
        chk("refused_rd_clr", 8'h00, bt(SB_NACKI));
        chk_stop();
        chk("master_ack", 8'h01, {7'h00, i2cms_slv_inst.mack_q[0]});
        chk("master_nak", 8'h00, {7'h00, i2cms_slv_inst.mack_q[1]});
    endtask : t_read

    task automatic t_refuse();
        i2cms_slv_inst.rx_q.delete();
        stops0 = i2cms_slv_inst.stops;
        refuse <= 1'b1;
        apb(1'b1, IDX_DATA, 8'ha0);
        apb(1'b1, IDX_CTRL, EN | GO | TX);
        wt(SB_TXE, 1'b1);
        apb(1'b1, IDX_DATA, 8'h11);
        wt(SB_NACKI, 1'b1);
        chk("ack_refused", 8'h00, bt(SB_ACK));
        chk("irq_refused", 8'h01, {7'h00, irq});
        chk("pending_byte", 8'h00, bt(SB_TXE));
        // stop and flush, no tx irq
        apb(1'b1, IDX_CTRL, EN | SP | FL);
        wt(SB_BUSY, 1'b0);
        chk("refused_clear", 8'h00, bt(SB_NACKI));
        chk("flush_empty", 8'h01, bt(SB_TXE));
        chk("bytes_sent", 8'h01, 8'(i2cms_slv_inst.rx_q.size()));
        chk_stop();
        stops0 = i2cms_slv_inst.stops;
        apb(1'b1, IDX_DATA, 8'ha1);
        apb(1'b1, IDX_CTRL, EN | GO);
        wt(SB_NACKI, 1'b1);
        chk("rx_full_refused", 8'h00, bt(SB_RXF));
        apb(1'b1, IDX_CTRL, EN | SP);
        wt(SB_BUSY, 1'b0);
        chk("refused_addr_clr", 8'h00, bt(SB_NACKI));
        chk_stop();
    endtask : t_refuse

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h00000000;
        refuse = 1'b0;
        rd_base = 8'h00;
        mismatches = 0;
        num_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_write10();
        t_restart();
        t_read();
        t_refuse();
        give_verdict();
    end
endmodule : testbench
